// *** hw/xpoint_gate_pkg.sv ***
// Package for the crosspoint profile gate: register map, field layouts, types.
// Assumes an AXI4-Lite master with 32-bit data and one clock domain.
package xpoint_gate_pkg;

  localparam int unsigned BUNCH_COUNT      = 4;
  localparam int unsigned PROFILE_W        = 5;
  localparam int unsigned DIVISOR_W        = 4;
  localparam int unsigned SAMPLE_W         = 24;
  localparam int unsigned XP_COUNT         = 8;
  localparam int unsigned XP_INDEX_W       = 3;
  localparam int unsigned MAX_SOURCE_TOTAL = 1024;
  localparam int unsigned MONITOR_CLASSES  = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_BUNCH_PROFILE   = 8'h00;
  localparam logic [7:0] ADDR_MONITOR_PROFILE = 8'h04;
  localparam logic [7:0] ADDR_TRANSITION      = 8'h08;
  localparam logic [7:0] ADDR_ROUTE           = 8'h0C;
  localparam logic [7:0] ADDR_STATUS          = 8'h10;
  localparam logic [7:0] ADDR_XP_BASE         = 8'h20;

  // Crosspoint word layout
  localparam int unsigned XP_PROFILE_LSB = 0;
  localparam int unsigned XP_DIVISOR_LSB = 8;
  localparam int unsigned XP_CLASS_LSB   = 16;
  localparam int unsigned XP_BUNCH_LSB   = 20;
  localparam int unsigned XP_ENABLE_BIT  = 24;

  // Route word layout
  localparam int unsigned ROUTE_PROFILE_LSB = 0;
  localparam int unsigned ROUTE_CLASS_LSB   = 8;

  // Transition position at which cut and datapath switches change over
  localparam logic [7:0] TRANSITION_MIDPOINT = 8'h80;
  localparam logic [7:0] TRANSITION_RESET    = 8'h00;
  localparam logic [3:0] DIVISOR_RESET       = 4'h1;
  localparam logic [4:0] PROFILE_RESET       = 5'h00;
  localparam logic [1:0] RESP_OKAY           = 2'b00;
  localparam logic [1:0] RESP_SLVERR         = 2'b10;

  typedef enum logic [3:0] {
    zero_gain_class    = 4'h0,
    unity_gain_class   = 4'h1,
    a_datapath_switch  = 4'h2,
    b_datapath_switch  = 4'h3,
    a_fader_crosspoint = 4'h4,
    b_fader_crosspoint = 4'h5,
    a_cut_crosspoint   = 4'h6,
    b_cut_crosspoint   = 4'h7
  } crosspoint_gain_class_e;

  typedef enum logic [2:0] {
    no_monitor_class = 3'h0,
    preview_class    = 3'h1,
    meter_class      = 3'h2,
    monitor_class    = 3'h3,
    clean_feed_class = 3'h4
  } output_monitor_class_e;

  typedef struct packed {
    logic                   enable;
    logic [1:0]             bunch;
    crosspoint_gain_class_e crosspoint_gain_class;
    logic [DIVISOR_W-1:0]   attenuation_divisor;
    logic [PROFILE_W-1:0]   source_select_profile;
  } crosspoint_cfg_s;

  typedef struct packed {
    output_monitor_class_e output_monitor_class;
    logic [PROFILE_W-1:0]  output_enable_profile;
  } route_cfg_s;

  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] data;
  } sample_s;

endpackage

// *** hw/sample_skid_buffer.sv ***
// Two-entry valid/ready buffer for mixed samples.
// Assumes aclk and a synchronous active-low aresetn.
`timescale 1ns/10ps
`default_nettype none
module sample_skid_buffer #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            rd;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W:0]              count;
  } buf_state_s;

  buf_state_s state;
  buf_state_s next_state;
  logic       push;
  logic       pop;

  assign in_ready  = (state.count < (PTR_W+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data  = state.mem[state.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr] = in_data;
      next_state.wr = (state.wr == PTR_W'(DEPTH-1)) ? '0 : state.wr + 1'b1;
    end
    if (pop) begin
      next_state.rd = (state.rd == PTR_W'(DEPTH-1)) ? '0 : state.rd + 1'b1;
    end
    next_state.count = state.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// *** hw/xpoint_profile_gate.sv ***
// Crosspoint profile gate: per-crosspoint bunch/profile gating, divisor
// attenuation, mix summing and monitor-profile output gating.
// Assumes an AXI4-Lite master on aclk and one sample per crosspoint per src_valid beat.
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module xpoint_profile_gate
  import xpoint_gate_pkg::*;
#(
  parameter int unsigned CROSSPOINTS = xpoint_gate_pkg::XP_COUNT
) (
  input  wire logic                                    aclk,
  input  wire logic                                    aresetn,
  input  wire logic [7:0]                              s_axi_awaddr,
  input  wire logic                                    s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire logic [31:0]                             s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  input  wire logic                                    s_axi_wvalid,
  output logic                                         s_axi_wready,
  output logic [1:0]                                   s_axi_bresp,
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  input  wire logic [7:0]                              s_axi_araddr,
  input  wire logic                                    s_axi_arvalid,
  output logic                                         s_axi_arready,
  output logic [31:0]                                  s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  input  wire logic [CROSSPOINTS-1:0][xpoint_gate_pkg::SAMPLE_W-1:0] src_data,
  input  wire logic                                    src_valid,
  output logic                                         src_ready,
  output logic [xpoint_gate_pkg::SAMPLE_W-1:0]         dst_data,
  output logic                                         dst_valid,
  input  wire logic                                    dst_ready,
  output logic                                         dst_enable
);

  typedef struct packed {
    logic                                         aw_held;
    logic [7:0]                                   aw_addr;
    logic                                         w_held;
    logic [31:0]                                  w_data;
    logic [3:0]                                   w_strb;
    logic                                         bvalid;
    logic [1:0]                                   bresp;
    logic                                         rvalid;
    logic [31:0]                                  rdata;
    logic [1:0]                                   rresp;
    logic [BUNCH_COUNT-1:0][PROFILE_W-1:0]        bunch_profile;
    logic [MONITOR_CLASSES-1:0][PROFILE_W-1:0]    monitor_profile;
    logic [7:0]                                   transition;
    route_cfg_s                                   route;
    logic [CROSSPOINTS-1:0][$bits(crosspoint_cfg_s)-1:0] xp;
    logic                                         mix_valid;
    logic signed [SAMPLE_W+3:0]                   mix_sum;
    logic                                         route_on;
    logic                                         out_enable;
  } gate_state_s;

  gate_state_s     state;
  gate_state_s     next_state;
  logic            buf_in_ready;
  logic            buf_out_valid;
  logic [SAMPLE_W:0] buf_in_data;
  logic [SAMPLE_W:0] buf_out_data;
  logic            buf_out_route;
  crosspoint_cfg_s [CROSSPOINTS-1:0] xp_cfg;
  logic [CROSSPOINTS-1:0] xp_live;
  logic signed [SAMPLE_W+3:0] sum_comb;
  logic            route_match;

  // Combinational gating and sum over all crosspoints
  always_comb begin
    crosspoint_cfg_s cfg;
    logic [PROFILE_W-1:0] live;
    logic pass;
    logic b_side;
    logic [DIVISOR_W-1:0] div;
    cfg = '0;
    live = '0;
    pass = 1'b0;
    b_side = 1'b0;
    div = DIVISOR_RESET;
    sum_comb = '0;
    for (int i = 0; i < CROSSPOINTS; i++) begin
      cfg = crosspoint_cfg_s'(state.xp[i]);
      live = state.bunch_profile[cfg.bunch];
      b_side = (state.transition >= TRANSITION_MIDPOINT);
      unique case (cfg.crosspoint_gain_class)
        zero_gain_class:    pass = 1'b0;
        unity_gain_class:   pass = 1'b1;
        a_datapath_switch:  pass = !b_side;
        b_datapath_switch:  pass = b_side;
        a_cut_crosspoint:   pass = !b_side;
        b_cut_crosspoint:   pass = b_side;
        a_fader_crosspoint: pass = (state.transition != 8'hFF);
        b_fader_crosspoint: pass = (state.transition != 8'h00);
        default:            pass = 1'b0;
      endcase
      xp_live[i] = cfg.enable && pass && (cfg.source_select_profile == live);
      div = (cfg.attenuation_divisor == '0) ? DIVISOR_RESET : cfg.attenuation_divisor;
      if (xp_live[i]) begin
        sum_comb = sum_comb + (SAMPLE_W+4)'($signed(src_data[i]) /
                   $signed({1'b0, div}));
      end
    end
  end

  assign route_match = (state.route.output_monitor_class == no_monitor_class) ||
    (state.route.output_enable_profile ==
     state.monitor_profile[state.route.output_monitor_class[1:0] - 2'd1]);

  always_comb begin
    logic [31:0] rd;
    int unsigned idx;
    crosspoint_cfg_s xc;
    rd = '0;
    idx = 0;
    xc = '0;
    next_state = state;
    // Write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (state.aw_held && state.w_held && !state.bvalid) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = RESP_OKAY;
      if (state.aw_addr == ADDR_BUNCH_PROFILE) begin
        for (int b = 0; b < BUNCH_COUNT; b++) begin
          if (state.w_strb[b]) begin
            next_state.bunch_profile[b] = state.w_data[8*b +: PROFILE_W];
          end
        end
      end else if (state.aw_addr == ADDR_MONITOR_PROFILE) begin
        for (int m = 0; m < MONITOR_CLASSES; m++) begin
          if (state.w_strb[m]) begin
            next_state.monitor_profile[m] = state.w_data[8*m +: PROFILE_W];
          end
        end
      end else if (state.aw_addr == ADDR_TRANSITION) begin
        if (state.w_strb[0]) next_state.transition = state.w_data[7:0];
      end else if (state.aw_addr == ADDR_ROUTE) begin
        next_state.route.output_enable_profile =
          state.w_data[ROUTE_PROFILE_LSB +: PROFILE_W];
        next_state.route.output_monitor_class =
          output_monitor_class_e'(state.w_data[ROUTE_CLASS_LSB +: 3]);
      end else if (state.aw_addr >= ADDR_XP_BASE &&
                   state.aw_addr < ADDR_XP_BASE + 8'(4*CROSSPOINTS) &&
                   state.aw_addr[1:0] == 2'b00) begin
        idx = 32'(state.aw_addr - ADDR_XP_BASE) >> 2;
        // Fields sit at fixed bit positions, not in struct packing order
        xc.enable                = state.w_data[XP_ENABLE_BIT];
        xc.bunch                 = state.w_data[XP_BUNCH_LSB +: 2];
        xc.crosspoint_gain_class =
          crosspoint_gain_class_e'(state.w_data[XP_CLASS_LSB +: 4]);
        xc.attenuation_divisor   = state.w_data[XP_DIVISOR_LSB +: DIVISOR_W];
        xc.source_select_profile = state.w_data[XP_PROFILE_LSB +: PROFILE_W];
        next_state.xp[idx]       = xc;
      end else begin
        next_state.bresp = RESP_SLVERR;
      end
    end
    if (state.bvalid && s_axi_bready) next_state.bvalid = 1'b0;

    if (s_axi_arvalid && s_axi_arready) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = RESP_OKAY;
      if (s_axi_araddr == ADDR_BUNCH_PROFILE) begin
        for (int b = 0; b < BUNCH_COUNT; b++) rd[8*b +: PROFILE_W] = state.bunch_profile[b];
      end else if (s_axi_araddr == ADDR_MONITOR_PROFILE) begin
        for (int m = 0; m < MONITOR_CLASSES; m++) rd[8*m +: PROFILE_W] = state.monitor_profile[m];
      end else if (s_axi_araddr == ADDR_TRANSITION) begin
        rd[7:0] = state.transition;
      end else if (s_axi_araddr == ADDR_ROUTE) begin
        rd[ROUTE_PROFILE_LSB +: PROFILE_W] = state.route.output_enable_profile;
        rd[ROUTE_CLASS_LSB +: 3] = state.route.output_monitor_class;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        rd[CROSSPOINTS-1:0] = xp_live;
        rd[16] = state.out_enable;
      end else if (s_axi_araddr >= ADDR_XP_BASE &&
                   s_axi_araddr < ADDR_XP_BASE + 8'(4*CROSSPOINTS) &&
                   s_axi_araddr[1:0] == 2'b00) begin
        idx = 32'(s_axi_araddr - ADDR_XP_BASE) >> 2;
        xc = crosspoint_cfg_s'(state.xp[idx]);
        rd[XP_ENABLE_BIT]               = xc.enable;
        rd[XP_BUNCH_LSB +: 2]           = xc.bunch;
        rd[XP_CLASS_LSB +: 4]           = xc.crosspoint_gain_class;
        rd[XP_DIVISOR_LSB +: DIVISOR_W] = xc.attenuation_divisor;
        rd[XP_PROFILE_LSB +: PROFILE_W] = xc.source_select_profile;
      end else begin
        next_state.rresp = RESP_SLVERR;
      end
      next_state.rdata = rd;
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end

    // Mix stage: one sample set in, one gated sum out
    if (state.mix_valid && buf_in_ready) next_state.mix_valid = 1'b0;
    if (src_valid && src_ready) begin
      next_state.mix_valid = 1'b1;
      next_state.mix_sum   = sum_comb;
      next_state.route_on  = route_match;
    end
    if (buf_out_valid && dst_ready) next_state.out_enable = buf_out_route;
  end

  // Stall the sources while the mix stage cannot hand its word on
  assign src_ready     = !state.mix_valid || buf_in_ready;
  assign s_axi_awready = !state.aw_held;
  assign s_axi_wready  = !state.w_held;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign dst_enable    = state.out_enable;
  assign xp_cfg        = state.xp;
  // Route bit rides with its word, so dst_enable follows the sample that leaves
  assign buf_in_data   = {state.route_on,
                          state.route_on ? state.mix_sum[SAMPLE_W-1:0] : SAMPLE_W'(0)};

  sample_skid_buffer #(
    .WIDTH (SAMPLE_W + 1),
    .DEPTH (2)
  ) u_out_buffer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (state.mix_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (dst_ready),
    .out_data  (buf_out_data)
  );
  assign dst_valid = buf_out_valid;
  assign dst_data  = buf_out_data[SAMPLE_W-1:0];
  assign buf_out_route = buf_out_data[SAMPLE_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  a_bunch_reset_zero: assert property (@(posedge aclk)
    $rose(aresetn) |-> state.bunch_profile == '0)
    else $error("bunch profile not zero after reset");

  a_write_takes_two: assert property (@(posedge aclk) disable iff (!aresetn)
    (state.aw_held && state.w_held && !state.bvalid) |=> state.bvalid)
    else $error("write response missing");

  a_route_gate_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (src_valid && src_ready && !route_match) |=> !state.route_on)
    else $error("unmatched route kept open");

  a_xp_profile_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    xp_live[0] |-> xp_cfg[0].source_select_profile ==
      state.bunch_profile[xp_cfg[0].bunch])
    else $error("crosspoint live with wrong profile");

  a_cut_midpoint: assert property (@(posedge aclk) disable iff (!aresetn)
    (xp_cfg[2].crosspoint_gain_class == a_cut_crosspoint &&
     state.transition >= TRANSITION_MIDPOINT) |-> !xp_live[2])
    else $error("cut crosspoint open past midpoint");

  a_source_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (state.mix_valid && !buf_in_ready) |-> !src_ready)
    else $error("source not stalled");

  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");

  a_sum_latched: assert property (@(posedge aclk) disable iff (!aresetn)
    (src_valid && src_ready) |=> state.mix_sum == $past(sum_comb))
    else $error("mix sum not latched");

  a_default_profile: assert property (@(posedge aclk) disable iff (!aresetn)
    (xp_cfg[0].enable &&
     xp_cfg[0].crosspoint_gain_class == unity_gain_class &&
     xp_cfg[0].source_select_profile == PROFILE_RESET &&
     state.bunch_profile[xp_cfg[0].bunch] == PROFILE_RESET)
      |-> xp_live[0])
    else $error("default profile crosspoint shut");

  a_clean_feed_index: assert property (@(posedge aclk) disable iff (!aresetn)
    (state.route.output_monitor_class == clean_feed_class) |->
      route_match == (state.route.output_enable_profile == state.monitor_profile[3]))
    else $error("clean feed class read wrong profile");

  a_b_cut_side: assert property (@(posedge aclk) disable iff (!aresetn)
    (xp_cfg[3].crosspoint_gain_class == b_cut_crosspoint &&
     state.transition < TRANSITION_MIDPOINT) |-> !xp_live[3])
    else $error("cut crosspoint open before midpoint");

  a_datapath_side: assert property (@(posedge aclk) disable iff (!aresetn)
    (xp_cfg[2].crosspoint_gain_class == a_datapath_switch &&
     state.transition >= TRANSITION_MIDPOINT) |-> !xp_live[2])
    else $error("datapath switch open past changeover");

  a_reset_quiet: assert property (@(posedge aclk)
    $rose(aresetn) |-> !dst_valid && !dst_enable && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");

  a_enable_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (buf_out_valid && dst_ready) |=> dst_enable == $past(buf_out_route))
    else $error("dst_enable not from drained word");

  a_gated_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (buf_out_valid && !buf_out_route) |-> dst_data == '0)
    else $error("gated output carries data");

  a_entry_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    $countones(xp_live) <= MAX_SOURCE_TOTAL)
    else $error("too many live source entries");

endmodule
`default_nettype wire

// *** testbench/profile_controller_model.sv ***
// Automation controller model: writes and reads the live profile registers.
// Assumes an AXI4-Lite slave on aclk; the bench calls the tasks by hierarchy.
`timescale 1ns/10ps
`default_nettype none
module profile_controller_model (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  initial begin
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h00000000;
    s_axi_wstrb   = 4'hF;
    s_axi_wvalid  = 1'b0;
    // Response readies stay high, so back-to-back calls never re-drive them
    s_axi_bready  = 1'b1;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b1;
  end

  // Live profile values only ever arrive as whole-word writes
  task automatic write_reg(input logic [7:0] addr, input logic [31:0] data,
                           output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_xpoint_profile_gate.sv ***
// Testbench for the crosspoint profile gate: register access, gating, stall.
// Assumes the controller model drives AXI; the bench drives the sample stream.
`timescale 1ns/10ps
`default_nettype none
module test_xpoint_profile_gate;
  import xpoint_gate_pkg::*;
  logic                                aclk;
  logic                                aresetn;
  logic [7:0]                          awaddr, araddr;
  logic                                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                                arvalid, arready, rvalid, rready;
  logic [31:0]                         wdata, rdata, rd;
  logic [3:0]                          wstrb;
  logic [1:0]                          bresp, rresp, resp;
  logic [XP_COUNT-1:0][SAMPLE_W-1:0]   src_data;
  logic                                src_valid, src_ready, dst_valid, dst_ready, dst_enable;
  logic [SAMPLE_W-1:0]                 dst_data;
  int                                  mismatches, compares, n;
  int                                  cycles = 0;

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  profile_controller_model profile_controller_model_i (.aclk(aclk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  xpoint_profile_gate xpoint_profile_gate_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready), .dst_data(dst_data),
    .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_enable(dst_enable));

  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    profile_controller_model_i.write_reg(addr, data, resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask

  // Enable bit set, fields placed as in the crosspoint word
  function automatic logic [31:0] xp_word(input logic [3:0] cls, input logic [1:0] bunch,
                                          input logic [4:0] prof, input logic [3:0] div);
    return {7'h00, 1'b1, 2'b00, bunch, cls, 4'h0, div, 3'b000, prof};
  endfunction

  // The sink stays ready outside the stall test, so no wait is needed here
  task automatic sample_check(input logic [SAMPLE_W-1:0] exp);
    src_valid <= 1'b1;
    do @(posedge aclk); while (!src_ready);
    src_valid <= 1'b0;
    do @(posedge aclk); while (!dst_valid);
    check({8'h00, dst_data}, {8'h00, exp});
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    mismatches = 0;
    compares = 0;
    aresetn = 1'b0;
    src_valid = 1'b0;
    dst_ready = 1'b1;
    for (int i = 0; i < XP_COUNT; i++) src_data[i] = 24'h050000;
    src_data[0] = 24'h000100;
    src_data[1] = 24'h000200;
    src_data[2] = 24'h000030;
    src_data[3] = 24'h000004;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      profile_controller_model_i.read_reg(8'(4 * i), rd, resp);
      check(rd, 32'h00000000);
    end
    profile_controller_model_i.read_reg(8'h40, rd, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(ADDR_XP_BASE, xp_word(unity_gain_class, 2'h0, 5'h00, 4'h0));
    wr(ADDR_XP_BASE + 8'h04, xp_word(unity_gain_class, 2'h1, 5'h04, 4'h2));
    profile_controller_model_i.read_reg(ADDR_XP_BASE + 8'h04, rd, resp);
    check(rd, xp_word(unity_gain_class, 2'h1, 5'h04, 4'h2));
    sample_check(24'h000100);
    wr(ADDR_BUNCH_PROFILE, 32'h00000400);
    profile_controller_model_i.read_reg(ADDR_BUNCH_PROFILE, rd, resp);
    check(rd, 32'h00000400);
    sample_check(24'h000200);
    wr(ADDR_BUNCH_PROFILE, 32'h00000401);
    sample_check(24'h000100);
    profile_controller_model_i.read_reg(ADDR_STATUS, rd, resp);
    check(rd, 32'h00010002);
    wr(ADDR_BUNCH_PROFILE, 32'h00000001);
    for (int p = 0; p < 3; p++) begin
      // Faders pass on both sides away from the end stops
      wr(ADDR_XP_BASE + 8'h08, xp_word(p == 0 ? a_fader_crosspoint :
                                       p == 1 ? a_cut_crosspoint : a_datapath_switch,
                                       2'h0, 5'h01, 4'h1));
      wr(ADDR_XP_BASE + 8'h0C, xp_word(p == 0 ? b_fader_crosspoint :
                                       p == 1 ? b_cut_crosspoint : b_datapath_switch,
                                       2'h0, 5'h01, 4'h1));
      wr(ADDR_TRANSITION, 32'h0000007F);
      sample_check(p == 0 ? 24'h000034 : 24'h000030);
      wr(ADDR_TRANSITION, 32'h00000080);
      sample_check(p == 0 ? 24'h000034 : 24'h000004);
    end
    for (int c = 1; c <= MONITOR_CLASSES; c++) begin
      wr(ADDR_ROUTE, {21'h0, 3'(c), 3'h0, 5'h03});
      wr(ADDR_MONITOR_PROFILE, 32'h00000003 << (8 * (c - 1)));
      sample_check(24'h000004);
      repeat (2) @(posedge aclk);
      check({31'h0, dst_enable}, 32'h00000001);
      wr(ADDR_MONITOR_PROFILE, 32'h03030303 & ~(32'hFF << (8 * (c - 1))));
      sample_check(24'h000000);
      repeat (2) @(posedge aclk);
      check({31'h0, dst_enable}, 32'h00000000);
    end
    wr(ADDR_ROUTE, 32'h00000000);
    // Stalled sink: mix stage plus two buffer entries fill, then refuse
    dst_ready <= 1'b0;
    n = 0;
    src_valid <= 1'b1;
    src_data[3] <= 24'h000001;
    repeat (8) begin
      @(posedge aclk);
      if (src_ready) begin
        n++;
        src_data[3] <= 24'(n + 1);
      end
    end
    src_valid <= 1'b0;
    check(32'(n), 32'h00000003);
    dst_ready <= 1'b1;
    for (int j = 1; j <= n; j++) begin
      do @(posedge aclk); while (!dst_valid);
      check({8'h00, dst_data}, 32'(j));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
